// >>> verilog/qsf_front_end.sv
// Purpose: Serial interface front end of a quad-lane serial flash.
// Assumes: Serial clock half period is at least four clk_i periods.
// Notes:   Array, status register and protection live outside this block.

module qsf_front_end
  import qsf_pkg::*;
#(
  parameter logic [UID_W-1:0] UNIQUE_ID = 128'h5A5A_0000_1111_2222_3333_4444_5555_A5A5
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic [3:0] data_lane_i,
  input wire logic quad_enable_bit_i,
  input wire logic busy_i,
  input wire logic wrap_en_i,
  input wire logic [1:0] wrap_sel_i,
  input wire logic [3:0] sec_lock_i,
  input wire logic [7:0] mem_rdata_i,
  output logic [3:0] data_lane_o,
  output logic [3:0] data_lane_oe_o,
  output qsf_mem_req_t mem_req_o,
  output qsf_erase_t erase_o,
  output qsf_fwd_t fwd_o,
  output logic paused_o,
  output logic abandon_o
);

  typedef enum {ST_CMD, ST_ADDR, ST_DUMMY, ST_RDATA, ST_WDATA, ST_ERASE, ST_FWD,
                ST_IGNORE} qsf_state_t;

  // ----------------------------------------------------------------------
  // Command decoder.
  // ----------------------------------------------------------------------
  function automatic qsf_cmd_info_t decode(input logic [7:0] c);
    qsf_cmd_info_t i;
    i = '0;
    i.known = 1'b1;
    case (c)
      CMD_READ: i.rd = 1'b1;
      CMD_FAST: begin i.rd = 1'b1; i.dummy = DUMMY_STD; end
      CMD_DOUT: begin i.rd = 1'b1; i.dt_lw = LW_X2; i.dummy = DUMMY_STD; end
      CMD_DIO: begin i.rd = 1'b1; i.ad_lw = LW_X2; i.dt_lw = LW_X2; i.dummy = DUMMY_DIO; end
      CMD_QOUT: begin i.rd = 1'b1; i.quad = 1'b1; i.dt_lw = LW_X4; i.dummy = DUMMY_STD; end
      CMD_QIO:
      begin
        i.rd = 1'b1; i.quad = 1'b1; i.wrap = 1'b1;
        i.ad_lw = LW_X4; i.dt_lw = LW_X4; i.dummy = DUMMY_QIO;
      end
      CMD_QWORD:
      begin
        i.rd = 1'b1; i.quad = 1'b1; i.wrap = 1'b1;
        i.ad_lw = LW_X4; i.dt_lw = LW_X4; i.dummy = DUMMY_QWORD;
      end
      CMD_PROG: i.wr = 1'b1;
      CMD_QPROG: begin i.wr = 1'b1; i.quad = 1'b1; i.dt_lw = LW_X4; end
      CMD_SECT: begin i.er = 1'b1; i.esize = ER_SECT; end
      CMD_BLK32: begin i.er = 1'b1; i.esize = ER_BLK32; end
      CMD_BLK64: begin i.er = 1'b1; i.esize = ER_BLK64; end
      CMD_UID: begin i.rd = 1'b1; i.uid = 1'b1; i.dummy = DUMMY_STD; end
      CMD_SREAD: begin i.rd = 1'b1; i.sec = 1'b1; i.dummy = DUMMY_STD; end
      CMD_SPROG: begin i.wr = 1'b1; i.sec = 1'b1; end
      default: i.known = 1'b0;
    endcase
    return i;
  endfunction

  // Next byte address: page, identifier, wrap window or whole array.
  function automatic logic [ADDR_W-1:0] advance(input logic [ADDR_W-1:0] a,
                                               input qsf_cmd_info_t i,
                                               input logic wrap_en,
                                               input logic [1:0] wsel);
    logic [ADDR_W-1:0] m;
    logic [ADDR_W-1:0] inc;
    inc = a + ADDR_ONE;
    m = (ADDR_ONE << (WRAP_BASE_LOG2 + wsel)) - ADDR_ONE;
    if (i.wr || i.sec)
      m = PAGE_MASK; // R14 R19 R22
    else if (i.uid)
      m = UID_MASK; // R18
    else if (!(i.wrap && wrap_en))
      m = ADDR_ALL;
    return (a & ~m) | (inc & m); // R17
  endfunction

  // ----------------------------------------------------------------------
  // Pin sampling.
  // ----------------------------------------------------------------------
  logic [5:0] pins_f;
  logic sclk_f, csn_f, hold_n;
  logic [3:0] lane_f;

  qsf_sync #(.W(6), .RST(SYNC_RST)) u_sync (
    .clk_i(clk_i),
    .reset_n_i(reset_n_i),
    .async_i({sclk_i, cs_n_i, data_lane_i}),
    .level_o(pins_f)
  );

  assign sclk_f = pins_f[5];
  assign csn_f = pins_f[4];
  assign lane_f = pins_f[3:0];
  assign hold_n = pins_f[3];

  // ----------------------------------------------------------------------
  // Transaction state.
  // ----------------------------------------------------------------------
  qsf_state_t state_q, state_d;
  qsf_cmd_info_t info_q, info_d, dec;
  logic sclk_q, sclk_d, csn_q, csn_d, paused_q, paused_d, wait_q, wait_d;
  logic drive_q, drive_d, abandon_q, abandon_d;
  logic [5:0] cnt_q, cnt_d, len;
  logic [2:0] fcnt_q, fcnt_d;
  logic [1:0] pend_q, pend_d;
  logic [23:0] rx_q, rx_d;
  logic [7:0] tx_q, tx_d, nxt_q, nxt_d, src;
  logic [3:0] fidx_q, fidx_d, out_q, out_d, oe_q, oe_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [UID_W-1:0] uid_sh;
  logic [1:0] lw;
  logic active, rise, fall, last, fetch;
  qsf_mem_req_t mem_q, mem_d;
  qsf_erase_t er_q, er_d;
  qsf_fwd_t fwd_q, fwd_d;

  // Edges count only while selected and not paused; levels track always.
  assign active = !csn_f && !paused_q && !wait_q; // R10 R12
  assign rise = active && sclk_f && !sclk_q; // R1 R2
  assign fall = active && !sclk_f && sclk_q; // R1 R2
  assign dec = decode(rx_d[7:0]);
  assign uid_sh = UNIQUE_ID << {fidx_q, 3'h0};

  // Lane width and length of the current phase.
  always_comb
  begin
    lw = info_q.dt_lw;
    len = BYTE_BITS >> info_q.dt_lw;
    case (state_q)
      ST_CMD: begin lw = LW_X1; len = CMD_BITS; end // R21
      ST_ADDR: begin lw = info_q.ad_lw; len = ADDR_BITS >> info_q.ad_lw; end
      ST_DUMMY: begin lw = info_q.ad_lw; len = info_q.dummy; end
      ST_FWD: begin lw = LW_X1; len = BYTE_BITS; end
      default: ;
    endcase
    last = (cnt_q + 6'h01) == len;
  end

  // Next-state logic of the whole front end.
  always_comb
  begin
    state_d = state_q;
    info_d = info_q;
    sclk_d = sclk_f;
    csn_d = csn_f;
    paused_d = paused_q;
    wait_d = wait_q;
    drive_d = drive_q;
    abandon_d = 1'b0;
    cnt_d = cnt_q;
    fcnt_d = fcnt_q;
    pend_d = {pend_q[0], 1'b0};
    rx_d = rx_q;
    tx_d = tx_q;
    nxt_d = nxt_q;
    fidx_d = fidx_q;
    out_d = out_q;
    addr_d = addr_q;
    mem_d = '0;
    er_d = '0;
    fwd_d = '0;
    fetch = 1'b0;
    src = (fcnt_q == 3'h0) ? nxt_q : tx_q;
    // Pause follows the pin only while the clock is low and lane 3 is not data.
    if (csn_f || quad_enable_bit_i || wait_q)
      paused_d = 1'b0; // R6
    else if (!sclk_f)
      paused_d = !hold_n; // R8 R9
    // Chip select rising while paused drops the transaction.
    if (csn_f && !csn_q && paused_q)
    begin
      abandon_d = 1'b1; // R11
      wait_d = 1'b1;
    end
    else if (wait_q && csn_f && hold_n)
      wait_d = 1'b0; // R12
    if (rise)
    begin
      case (lw)
        LW_X2: rx_d = {rx_q[21:0], lane_f[1:0]}; // R3
        LW_X4: rx_d = {rx_q[19:0], lane_f}; // R4 R20
        default: rx_d = {rx_q[22:0], lane_f[0]}; // R21
      endcase
    end
    if (csn_f)
    begin
      state_d = ST_CMD;
      cnt_d = '0;
      fcnt_d = '0;
      drive_d = 1'b0;
      if (!csn_q && state_q == ST_ERASE && !paused_q)
      begin
        er_d.valid = 1'b1;
        er_d.size = info_q.esize;
        case (info_q.esize)
          ER_BLK32: er_d.addr = addr_q & ~BLK32_MASK; // R16
          ER_BLK64: er_d.addr = addr_q & ~BLK64_MASK; // R16 R22
          default: er_d.addr = addr_q & ~SECT_MASK; // R15 R22
        endcase
      end
    end
    else if (rise)
    begin
      cnt_d = last ? '0 : cnt_q + 6'h01;
      case (state_q)
        ST_CMD:
          if (last)
          begin
            info_d = dec;
            if (!dec.known)
            begin
              state_d = ST_FWD;
              fwd_d = '{valid: 1'b1, first: 1'b1, data: rx_d[7:0]};
            end
            else if ((dec.quad && !quad_enable_bit_i) || busy_i)
              state_d = ST_IGNORE; // R5 R7
            else
              state_d = ST_ADDR;
          end
        ST_ADDR:
          if (last)
          begin
            addr_d = rx_d[ADDR_W-1:0]; // R22
            if (info_q.er)
              state_d = ST_ERASE;
            else if (info_q.dummy != '0)
              state_d = ST_DUMMY;
            else if (info_q.rd)
            begin
              state_d = ST_RDATA;
              fetch = 1'b1;
            end
            else
              state_d = ST_WDATA;
          end
        ST_DUMMY:
          if (last)
          begin
            state_d = ST_RDATA;
            fetch = 1'b1;
          end
        ST_WDATA:
          if (last)
          begin
            mem_d.wr = !(info_q.sec && sec_lock_i[addr_q[SREG_LSB +: 2]]); // R19
            mem_d.sec = info_q.sec;
            mem_d.addr = addr_q;
            mem_d.wdata = rx_d[7:0];
            addr_d = advance(addr_q, info_q, wrap_en_i, wrap_sel_i); // R14
          end
        ST_FWD:
          if (last)
            fwd_d = '{valid: 1'b1, first: 1'b0, data: rx_d[7:0]};
        default: cnt_d = cnt_q;
      endcase
    end
    else if (fall && state_q == ST_RDATA)
    begin
      drive_d = 1'b1;
      case (info_q.dt_lw)
        LW_X2: begin out_d = {2'h0, src[7:6]}; tx_d = {src[5:0], 2'h0}; end // R3
        LW_X4: begin out_d = src[7:4]; tx_d = {src[3:0], 4'h0}; end // R4 R20
        default: begin out_d = {2'h0, src[7], 1'h0}; tx_d = {src[6:0], 1'h0}; end
      endcase
      fcnt_d = ((fcnt_q + 3'h1) == len[2:0]) ? 3'h0 : fcnt_q + 3'h1; // R2
      fetch = (fcnt_q == 3'h0);
    end
    // One fetch per byte; the byte arrives one cycle after the request.
    if (fetch)
    begin
      mem_d.rd = !info_d.uid;
      mem_d.sec = info_d.sec;
      mem_d.addr = addr_d;
      fidx_d = addr_d[3:0];
      pend_d[0] = 1'b1;
      addr_d = advance(addr_d, info_d, wrap_en_i, wrap_sel_i); // R17
    end
    if (pend_q[1])
      nxt_d = info_q.uid ? uid_sh[UID_W-1 -: 8] : mem_rdata_i; // R18
    case (info_q.dt_lw)
      LW_X2: oe_d = OE_X2;
      LW_X4: oe_d = OE_X4;
      default: oe_d = OE_X1;
    endcase
    if (!drive_d || paused_d || csn_f)
      oe_d = '0; // R10
  end

  // Registers of the front end.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      state_q <= ST_CMD;
      info_q <= '0;
      sclk_q <= 1'b0;
      csn_q <= 1'b1;
      paused_q <= 1'b0;
      wait_q <= 1'b0;
      drive_q <= 1'b0;
      abandon_q <= 1'b0;
      cnt_q <= '0;
      fcnt_q <= '0;
      pend_q <= '0;
      rx_q <= '0;
      tx_q <= '0;
      nxt_q <= '0;
      fidx_q <= '0;
      out_q <= '0;
      oe_q <= '0;
      addr_q <= '0;
      mem_q <= '0;
      er_q <= '0;
      fwd_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      info_q <= info_d;
      sclk_q <= sclk_d;
      csn_q <= csn_d;
      paused_q <= paused_d;
      wait_q <= wait_d;
      drive_q <= drive_d;
      abandon_q <= abandon_d;
      cnt_q <= cnt_d;
      fcnt_q <= fcnt_d;
      pend_q <= pend_d;
      rx_q <= rx_d;
      tx_q <= tx_d;
      nxt_q <= nxt_d;
      fidx_q <= fidx_d;
      out_q <= out_d;
      oe_q <= oe_d;
      addr_q <= addr_d;
      mem_q <= mem_d;
      er_q <= er_d;
      fwd_q <= fwd_d;
    end
  end

  assign data_lane_o = out_q;
  assign data_lane_oe_o = oe_q;
  assign mem_req_o = mem_q;
  assign erase_o = er_q;
  assign fwd_o = fwd_q;
  assign paused_o = paused_q;
  assign abandon_o = abandon_q;

  // ----------------------------------------------------------------------
  // Checks.
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);

  property p_paused_quiet;
    paused_q |-> (oe_q == 4'h0) && !rise && !fall;
  endproperty
  a_paused_quiet: assert property (p_paused_quiet) else $error("Paused but driving."); // R10

  property p_quad_no_pause;
    quad_enable_bit_i |=> !paused_q;
  endproperty
  a_quad_no_pause: assert property (p_quad_no_pause) else $error("Paused in quad mode."); // R6

  property p_pause_entry;
    $rose(paused_q) |-> !$past(sclk_f) && !$past(hold_n) && !$past(csn_f);
  endproperty
  a_pause_entry: assert property (p_pause_entry) else $error("Bad pause entry."); // R8

  property p_pause_exit;
    $fell(paused_q) && !$past(csn_f) && !$past(quad_enable_bit_i)
      |-> $past(hold_n) && !$past(sclk_f);
  endproperty
  a_pause_exit: assert property (p_pause_exit) else $error("Bad pause exit."); // R9

  property p_abandon;
    csn_f && !csn_q && paused_q |=> abandon_q && !er_q.valid ##1 !abandon_q;
  endproperty
  a_abandon: assert property (p_abandon) else $error("Abandon not flagged."); // R11

  property p_quad_refused;
    rise && state_q == ST_CMD && last && dec.known && dec.quad && !quad_enable_bit_i
      |=> state_q == ST_IGNORE;
  endproperty
  a_quad_refused: assert property (p_quad_refused) else $error("Quad command ran."); // R5

  property p_sector_align;
    er_q.valid && er_q.size == ER_SECT |-> (er_q.addr & SECT_MASK) == '0;
  endproperty
  a_sector_align: assert property (p_sector_align) else $error("Sector misaligned."); // R15

  property p_block_align;
    er_q.valid && er_q.size == ER_BLK64 |-> (er_q.addr & BLK64_MASK) == '0;
  endproperty
  a_block_align: assert property (p_block_align) else $error("Block misaligned."); // R16

  property p_page_stay;
    state_q == ST_WDATA && $past(state_q) == ST_WDATA
      |-> addr_q[ADDR_W-1:8] == $past(addr_q[ADDR_W-1:8]);
  endproperty
  a_page_stay: assert property (p_page_stay) else $error("Program left its page."); // R14

  property p_out_on_fall;
    $changed(out_q) |-> $past(fall);
  endproperty
  a_out_on_fall: assert property (p_out_on_fall) else $error("Output moved off a fall."); // R2

endmodule

// >>> verilog/qsf_pkg.sv
// Purpose: Shared constants and types of the quad serial flash front end.
// Assumes: One system clock; serial pins are sampled, not used as clocks.
// Notes:   Rules below.
// Function
// R1: Works with serial clock idling low or high, modes 0 and 3.
// R2: Samples inputs on rising serial clock, changes outputs on falling serial clock.
// R3: Dual output and dual I/O reads use lanes 0 and 1, two bits per clock.
// R4: Quad reads and quad program use four lanes; protect and pause pins are lanes 2, 3.
// R5: Quad commands only run when the quad enable bit is set.
// R6: Pause pin works only with quad enable clear; otherwise it is lane 3.
// R7: Pause halts only serial traffic; running program or erase continue.
// R8: Pause starts at falling pause pin with clock low, else when clock goes low.
// R9: Pause ends at rising pause pin with clock low, else when clock goes low.
// R10: While paused, output is released and serial input and clock are ignored.
// R11: Chip select rising during pause resets the interface and drops the transaction.
// R12: Host raises pause pin before lowering chip select after an abandoned transaction.
// R13: Host drives chip select high whenever the device is not addressed.
// R14: Programming works in 256-byte pages; one program stays within one page.
// R15: Uniform 4 KB erasable sectors of sixteen pages each.
// R16: Uniform 32 KB and 64 KB erasable blocks aligned to their size.
// R17: Continuous reads can wrap in aligned windows of 8, 16, 32 or 64 bytes.
// R18: A 128-bit unique identifier can be read by the host.
// R19: Four 256-byte security areas, each with a one-time lock against writes.
// R20: Quad transfers move four bits per clock.
// R21: Each transaction starts with a one-byte command, MSB first, on rising edges.
// R22: 21-bit address: bits 20-16 block, 20-12 sector, 7-0 page offset.

package qsf_pkg;

  // ----------------------------------------------------------------------
  // Geometry and field positions.
  // ----------------------------------------------------------------------
  localparam int unsigned ADDR_W = 21;
  localparam int unsigned UID_W = 128;
  localparam int unsigned WRAP_BASE_LOG2 = 3;
  localparam int unsigned SREG_LSB = 12;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 21'h000001;
  localparam logic [ADDR_W-1:0] ADDR_ALL = 21'h1FFFFF;
  localparam logic [ADDR_W-1:0] PAGE_MASK = 21'h0000FF;
  localparam logic [ADDR_W-1:0] UID_MASK = 21'h00000F;
  localparam logic [ADDR_W-1:0] SECT_MASK = 21'h000FFF;
  localparam logic [ADDR_W-1:0] BLK32_MASK = 21'h007FFF;
  localparam logic [ADDR_W-1:0] BLK64_MASK = 21'h00FFFF;

  // ----------------------------------------------------------------------
  // Command codes.
  // ----------------------------------------------------------------------
  localparam logic [7:0] CMD_READ = 8'h03;
  localparam logic [7:0] CMD_FAST = 8'h0B;
  localparam logic [7:0] CMD_DOUT = 8'h3B;
  localparam logic [7:0] CMD_DIO = 8'hBB;
  localparam logic [7:0] CMD_QOUT = 8'h6B;
  localparam logic [7:0] CMD_QIO = 8'hEB;
  localparam logic [7:0] CMD_QWORD = 8'hE7;
  localparam logic [7:0] CMD_PROG = 8'h02;
  localparam logic [7:0] CMD_QPROG = 8'h32;
  localparam logic [7:0] CMD_SECT = 8'h20;
  localparam logic [7:0] CMD_BLK32 = 8'h52;
  localparam logic [7:0] CMD_BLK64 = 8'hD8;
  localparam logic [7:0] CMD_UID = 8'h4B;
  localparam logic [7:0] CMD_SREAD = 8'h48;
  localparam logic [7:0] CMD_SPROG = 8'h42;

  // ----------------------------------------------------------------------
  // Phase lengths in bits or dummy clocks, lane codes, drive patterns and synchroniser reset.
  // ----------------------------------------------------------------------
  localparam logic [5:0] CMD_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS = 6'h18;
  localparam logic [5:0] BYTE_BITS = 6'h08;
  localparam logic [5:0] DUMMY_STD = 6'h08;
  localparam logic [5:0] DUMMY_DIO = 6'h04;
  localparam logic [5:0] DUMMY_QIO = 6'h06;
  localparam logic [5:0] DUMMY_QWORD = 6'h04;
  localparam logic [1:0] LW_X1 = 2'h0;
  localparam logic [1:0] LW_X2 = 2'h1;
  localparam logic [1:0] LW_X4 = 2'h2;
  localparam logic [3:0] OE_X1 = 4'h2;
  localparam logic [3:0] OE_X2 = 4'h3;
  localparam logic [3:0] OE_X4 = 4'hF;
  localparam logic [5:0] SYNC_RST = 6'h1F;

  // ----------------------------------------------------------------------
  // Types.
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ER_SECT, ER_BLK32, ER_BLK64} qsf_esize_t;

  typedef struct packed {
    logic known;
    logic quad;
    logic rd;
    logic wr;
    logic er;
    logic uid;
    logic sec;
    logic wrap;
    logic [1:0] ad_lw;
    logic [1:0] dt_lw;
    logic [5:0] dummy;
    qsf_esize_t esize;
  } qsf_cmd_info_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic sec;
    logic [ADDR_W-1:0] addr;
    logic [7:0] wdata;
  } qsf_mem_req_t;

  typedef struct packed {
    logic valid;
    qsf_esize_t size;
    logic [ADDR_W-1:0] addr;
  } qsf_erase_t;

  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } qsf_fwd_t;

endpackage

// >>> verilog/qsf_sync.sv
// Purpose: Three-stage pin synchroniser with a two-sample agreement filter.
// Assumes: Inputs are asynchronous to clk_i.
// Notes:   The level changes only when stages two and three agree.

module qsf_sync #(
  parameter int unsigned W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [W-1:0] async_i,
  output logic [W-1:0] level_o
);

  logic [W-1:0] s1_q, s2_q, s3_q, lvl_q;
  logic [W-1:0] lvl_d;

  // ----------------------------------------------------------------------
  // Agreement filter.
  // ----------------------------------------------------------------------
  // Only stages two and three are compared, never the first stage.
  always_comb
  begin
    lvl_d = ((s2_q ^ s3_q) & lvl_q) | (~(s2_q ^ s3_q) & s2_q);
  end

  // Registers of the chain and the filtered level.
  always_ff @(posedge clk_i)
  begin
    if (!reset_n_i)
    begin
      s1_q <= RST;
      s2_q <= RST;
      s3_q <= RST;
      lvl_q <= RST;
    end
    else
    begin
      s1_q <= async_i;
      s2_q <= s1_q;
      s3_q <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign level_o = lvl_q;

endmodule

// >>> bench/qsf_host_model.sv
// Purpose: Host controller model driving the serial pins.
// Assumes: A serial half period of HALF clocks.
// Notes:   Lanes nobody drives show a level that flips every clock.
module qsf_host_model
  import qsf_pkg::*;
(
  input wire logic clk_i,
  input wire logic [3:0] dev_i,
  input wire logic [3:0] dev_oe_i,
  output logic sclk_o,
  output logic cs_n_o,
  output logic [3:0] wire_o
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam int HALF = 8;
  logic [3:0] drv_q = 4'hD;
  logic [3:0] oe_q = 4'hD;
  logic flt_q = 1'b0;
  // Select is driven high from power-up on.
  initial cs_n_o = 1'b1;
  initial sclk_o = 1'b0;
  // The floating level changes every clock.
  always @(posedge clk_i) flt_q <= ~flt_q;
  // The wire level follows whoever drives it.
  always_comb
    for (int i = 0; i < 4; i++)
      wire_o[i] = oe_q[i] ? drv_q[i] : (dev_oe_i[i] ? dev_i[i] : flt_q);

  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // Sets select and the pause lane together.
  task automatic pins(input logic cs, input logic hold);
    @(posedge clk_i);
    cs_n_o <= cs;
    drv_q[3] <= hold;
    tick(HALF);
  endtask

  task automatic level(input logic v);
    @(posedge clk_i);
    sclk_o <= v;
    tick(HALF);
  endtask

  // The pause lane is high before select falls.
  task automatic frame_open(input logic idle);
    @(posedge clk_i);
    sclk_o <= idle;
    drv_q <= 4'hD;
    oe_q <= 4'hD;
    tick(HALF);
    pins(1'b0, 1'b1);
  endtask

  task automatic frame_close(input logic idle);
    level(idle);
    oe_q <= 4'hD;
    pins(1'b1, 1'b1);
  endtask

  // One serial clock: drive after the fall, sample at the rise.
  task automatic cycle(input logic [3:0] d, input logic [3:0] oe, output logic [3:0] q);
    @(posedge clk_i);
    sclk_o <= 1'b0;
    drv_q <= d;
    oe_q <= oe;
    tick(HALF);
    sclk_o <= 1'b1;
    q = wire_o;
    tick(HALF - 1);
  endtask

  // Sends a byte MSB first on one, two or four lanes.
  task automatic send(input logic [7:0] b, input int w);
    logic [3:0] q;
    repeat (8 / w)
    begin
      if (w == 1) cycle({3'b110, b[7]}, 4'hD, q);
      else if (w == 2) cycle({2'b11, b[7:6]}, 4'hF, q);
      else cycle(b[7:4], 4'hF, q);
      b = b << w;
    end
  endtask

  task automatic dummy(input int n);
    logic [3:0] q;
    repeat (n) cycle(4'hD, 4'hD, q);
  endtask

  // Collects a byte, releasing the lanes the device drives.
  task automatic recv(output logic [7:0] b, input int w);
    logic [3:0] q;
    b = 8'h00;
    repeat (8 / w)
    begin
      cycle(4'hC, w == 1 ? 4'hD : (w == 2 ? 4'hC : 4'h0), q);
      b = w == 1 ? {b[6:0], q[1]} : (w == 2 ? {b[5:0], q[1:0]} : {b[3:0], q});
    end
  endtask
endmodule

// >>> bench/testbench.sv
// Purpose: Self-checking bench of the flash front end.
// Assumes: Memory data follows a read request by one clock.
// Notes:   Wrap and lock inputs stay inactive.
module testbench
  import qsf_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic qe = 1'b0;
  logic busy = 1'b0;
  logic wrap_en = 1'b0;
  logic [1:0] wrap_sel = 2'h0;
  logic [3:0] sec_lock = 4'h0;
  logic sclk, cs_n, paused, abandon;
  logic [3:0] lanes, dev_lane, dev_oe;
  logic [7:0] mem_rdata_i, b;
  qsf_mem_req_t mem_req, last_wr;
  qsf_erase_t erase, last_er;
  qsf_fwd_t fwd;
  int bad_count = 0;
  int compares = 0;
  int rd_n = 0;
  int wr_n = 0;
  int ab_n = 0;

  always #5 clk_i = ~clk_i;

  qsf_front_end uut (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .data_lane_i(lanes), .quad_enable_bit_i(qe), .busy_i(busy),
    .wrap_en_i(wrap_en), .wrap_sel_i(wrap_sel), .sec_lock_i(sec_lock),
    .mem_rdata_i(mem_rdata_i), .data_lane_o(dev_lane), .data_lane_oe_o(dev_oe),
    .mem_req_o(mem_req), .erase_o(erase), .fwd_o(fwd), .paused_o(paused),
    .abandon_o(abandon)
  );

  qsf_host_model host (
    .clk_i(clk_i), .dev_i(dev_lane), .dev_oe_i(dev_oe), .sclk_o(sclk),
    .cs_n_o(cs_n), .wire_o(lanes)
  );

  function automatic logic [7:0] mval(input logic [20:0] a);
    return a[7:0] ^ {a[11:8], a[15:12]};
  endfunction

  // Memory answers a read request one clock later with a function of its address.
  always @(posedge clk_i)
    if (mem_req.rd) mem_rdata_i <= mval(mem_req.addr);

  // Counts the one-clock pulses the block raises.
  always @(posedge clk_i)
  begin
    if (mem_req.rd) rd_n <= rd_n + 1;
    if (mem_req.wr) wr_n <= wr_n + 1;
    if (mem_req.wr) last_wr <= mem_req;
    if (erase.valid) last_er <= erase;
    if (abandon) ab_n <= ab_n + 1;
  end

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic results();
    $display("compares %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic hdr(input logic [7:0] c, input logic [20:0] a, input int dm);
    host.send(c, 1);
    host.send({3'b000, a[20:16]}, 1);
    host.send(a[15:8], 1);
    host.send(a[7:0], 1);
    host.dummy(dm);
  endtask

  // Mode 0 single-lane read of the last two bytes of a page.
  task automatic t_read();
    host.frame_open(1'b0);
    hdr(CMD_READ, 21'h0123FE, 0);
    host.recv(b, 1);
    check("read byte 0", b, mval(21'h0123FE));
    host.recv(b, 1);
    check("read byte 1", b, mval(21'h0123FF));
    check("single oe", dev_oe, OE_X1);
    host.frame_close(1'b0);
    $display("test single read done");
  endtask

  // Mode 3 wide read; quad commands refused when quad is not enabled.
  task automatic wide(input logic [7:0] c, input int w, input logic q, input logic [3:0] oe);
    int n;
    @(posedge clk_i);
    qe <= q;
    n = rd_n;
    host.frame_open(1'b1);
    hdr(c, 21'h00ABC0, 8);
    host.recv(b, w);
    check("wide oe", dev_oe, oe);
    if (oe == 4'h0) check("refused fetch", rd_n, n);
    else check("wide byte", b, mval(21'h00ABC0));
    host.frame_close(1'b1);
    $display("test wide read done");
  endtask

  // Mode 3 program past the page end.
  task automatic t_prog();
    int n;
    n = wr_n;
    host.frame_open(1'b1);
    hdr(CMD_PROG, 21'h0456FF, 0);
    host.send(8'h3C, 1);
    host.send(8'hC3, 1);
    host.frame_close(1'b1);
    check("writes", wr_n, n + 2);
    check("wrap addr", last_wr.addr, 21'h045600);
    check("write data", last_wr.wdata, 8'hC3);
    busy <= 1'b1;
    host.frame_open(1'b1);
    hdr(CMD_PROG, 21'h0456FF, 0);
    host.send(8'h3C, 1);
    host.frame_close(1'b1);
    busy <= 1'b0;
    check("busy refused", wr_n, n + 2);
    $display("test program done");
  endtask

  // Each erase size aligns the address to its own size.
  task automatic t_erase();
    for (int i = 0; i < 3; i++)
    begin
      host.frame_open(1'b0);
      hdr(i == 0 ? CMD_SECT : (i == 1 ? CMD_BLK32 : CMD_BLK64), 21'h1ABCDE, 0);
      host.frame_close(1'b0);
      check("erase size", last_er.size, i);
      check("erase addr", last_er.addr,
            i == 0 ? 21'h1AB000 : (i == 1 ? 21'h1A8000 : 21'h1A0000));
    end
    $display("test erase done");
  endtask

  // Pause entry, ignored clocks, resume, then abandon.
  task automatic t_pause();
    int n;
    @(posedge clk_i);
    qe <= 1'b0;
    host.frame_open(1'b0);
    host.send(CMD_READ, 1);
    host.send(8'h01, 1);
    host.pins(1'b0, 1'b0);
    check("entry deferred", paused, 1'b0);
    host.level(1'b0);
    check("paused", paused, 1'b1);
    check("lanes released", dev_oe, 4'h0);
    repeat (3)
    begin
      host.level(1'b1);
      host.level(1'b0);
    end
    host.pins(1'b0, 1'b1);
    check("resumed", paused, 1'b0);
    host.send(8'h23, 1);
    host.send(8'h45, 1);
    host.recv(b, 1);
    check("read after pause", b, mval(21'h012345));
    host.pins(1'b0, 1'b0);
    host.level(1'b0);
    check("released in read", dev_oe, 4'h0);
    n = ab_n;
    host.pins(1'b1, 1'b0);
    check("abandon", ab_n, n + 1);
    host.pins(1'b1, 1'b1);
    @(posedge clk_i);
    qe <= 1'b1;
    host.frame_open(1'b0);
    host.send(CMD_READ, 1);
    host.level(1'b0);
    host.pins(1'b0, 1'b0);
    check("no pause with quad", paused, 1'b0);
    host.frame_close(1'b0);
    $display("test pause done");
  endtask

  initial
  begin
    repeat (12) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    t_read();
    wide(CMD_DOUT, 2, 1'b0, OE_X2);
    wide(CMD_QOUT, 1, 1'b0, 4'h0);
    wide(CMD_QOUT, 4, 1'b1, OE_X4);
    t_prog();
    t_erase();
    t_pause();
    t_read();
    results();
  end

  // Cuts a hang short well beyond the expected run.
  initial
  begin
    repeat (60000) @(posedge clk_i);
    bad_count++;
    results();
  end
endmodule
